// *** shared/sere_cfg.svh ***
`ifndef SERE_CFG_SVH
`define SERE_CFG_SVH

// Device address prefixes and layout
`define SERE_DA_MEM      4'hA
`define SERE_DA_SPC      4'hB
`define SERE_DA_ZERO     2'h0
`define SERE_DA_HALF     1
`define SERE_DA_RW       0

// Word address decode for the special areas
`define SERE_WA_SER      2'h2
`define SERE_WA_SEC      2'h0
`define SERE_WA_LCK_BIT  6
`define SERE_WA_LOCK     8'h40

// Area sizes
`define SERE_MEM_DEPTH   512
`define SERE_AREA_BYTES  16

// Lock status byte: flag sits in bit 1
`define SERE_LCK_POS     1

// Bit timing: one quarter of a bus bit
`define SERE_CLK_MHZ     25
`define SERE_QTR_NS      1280
`define SERE_QTR_CYC     ((`SERE_QTR_NS * `SERE_CLK_MHZ) / 1000)

`endif

// *** shared/sere_pkg.sv ***
package sere_pkg;

   // Device end states
   typedef enum logic [7:0] {
      D_IDLE = 8'h01, D_DEVA = 8'h02, D_WADR = 8'h04, D_WDAT = 8'h08,
      D_ACK  = 8'h10, D_RDAT = 8'h20, D_RACK = 8'h40, D_RNXT = 8'h80
   } sere_dst_t;

   // Area that the next byte comes from
   typedef enum logic [1:0] {
      AR_MEM = 2'h0, AR_SER = 2'h1, AR_SEC = 2'h2, AR_LCK = 2'h3
   } sere_area_t;

   // Controller end states
   typedef enum logic [4:0] {
      H_IDLE = 5'h01, H_STA = 5'h02, H_TX = 5'h04, H_RX = 5'h08, H_STO = 5'h10
   } sere_hst_t;

   // Commands of the controller end
   typedef enum logic [2:0] {
      OP_CUR = 3'h0, OP_RND = 3'h1, OP_SER = 3'h2,
      OP_SEC = 3'h3, OP_LCK = 3'h4, OP_PRB = 3'h5
   } sere_op_t;

   // Step within a command
   typedef enum logic [2:0] {
      PH_DAW = 3'h0, PH_WA = 3'h1, PH_PD = 3'h2,
      PH_DAR = 3'h3, PH_RD = 3'h4, PH_PSTA = 3'h5
   } sere_ph_t;

   typedef struct packed {
      logic [2:0] scl_m;
      logic [2:0] sda_m;
      logic [2:0] lck_m;
      logic       scl_f;
      logic       scl_p;
      logic       sda_f;
      logic       sda_p;
      logic       locked;
      sere_dst_t  st;
      sere_dst_t  nxt;
      sere_area_t area;
      sere_area_t smode;
      logic       half;
      logic [8:0] addr;
      logic [3:0] sidx;
      logic [3:0] kidx;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic       oe;
      logic       acking;
      logic       ackok;
   } sere_dev_t;

   typedef struct packed {
      logic       lclk;
      logic [7:0] cnt;
      logic [1:0] qp;
      sere_hst_t  st;
      sere_ph_t   ph;
      sere_op_t   op;
      logic [8:0] addr;
      logic [7:0] len;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic       scl;
      logic       oe;
      logic       ackn;
      logic       rd_valid;
      logic [7:0] rd_data;
      logic       done;
      logic       nack;
      logic       locked;
      logic [2:0] sda_m;
      logic       sda_f;
   } sere_ctl_t;

endpackage

// *** shared/sere_link_if.sv ***
`timescale 1ns/1ps
interface sere_link_if;
   logic link_clk;
   logic scl;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_d_o;
   logic sda_d_oe;
   logic sda;

   // Open-drain wire with pull-up: any enabled low output wins
   assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

   modport ctl (output link_clk, output scl, output sda_h_o, output sda_h_oe, input sda);
   modport dev (input link_clk, input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface // sere_link_if

// *** hdl/sere_dev.sv ***
`timescale 1ns/1ps
`include "sere_cfg.svh"
module sere_dev #(
   // Arbitrary serial number, not a real part value
   parameter logic [127:0] SERIAL_NUM = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
   // Reset
   input  wire logic        NRST,
   // Bus link, clocked by the link clock
   sere_link_if.dev         link,
   // Lock state, from outside the link domain
   input  wire logic        LOCKED,
   // Content load port, link clock domain
   input  wire logic        LD_WE,
   input  wire logic        LD_SEC,
   input  wire logic [8:0]  LD_ADDR,
   input  wire logic [7:0]  LD_DATA,
   // Status
   output logic             BUSY,
   output logic [8:0]       ADDR_CNT
);

   sere_pkg::sere_dev_t q;
   sere_pkg::sere_dev_t n;
   logic [7:0]          mem [`SERE_MEM_DEPTH];
   logic [7:0]          sec [`SERE_AREA_BYTES];
   logic [7:0]          byte_in;
   logic [7:0]          b;
   logic                rise;
   logic                fall;
   logic                start;
   logic                stop;
   logic                mem_m;
   logic                spc_m;

   ////////////////////////////////////////////////////////////////////////////
   // Content arrays: loaded by the user side, read by the engine
   always_ff @(posedge link.link_clk) begin
      if (LD_WE) begin
         if (LD_SEC) begin
            sec[LD_ADDR[3:0]] <= LD_DATA;
         end else begin
            mem[LD_ADDR] <= LD_DATA;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus engine
   always_comb begin
      n       = q;
      // Three-stage sync; a change counts once stages two and three agree
      n.scl_m = {q.scl_m[1:0], link.scl};
      n.sda_m = {q.sda_m[1:0], link.sda};
      n.lck_m = {q.lck_m[1:0], LOCKED};
      if (q.scl_m[1] == q.scl_m[2]) begin
         n.scl_f = q.scl_m[2];
      end
      if (q.sda_m[1] == q.sda_m[2]) begin
         n.sda_f = q.sda_m[2];
      end
      if (q.lck_m[1] == q.lck_m[2]) begin
         n.locked = q.lck_m[2];
      end
      n.scl_p = q.scl_f;
      n.sda_p = q.sda_f;

      // Edges and conditions seen on the filtered lines
      rise    = q.scl_f & ~q.scl_p;
      fall    = ~q.scl_f & q.scl_p;
      start   = q.scl_f & q.scl_p & q.sda_p & ~q.sda_f;
      stop    = q.scl_f & q.scl_p & ~q.sda_p & q.sda_f;
      byte_in = {q.sh[6:0], q.sda_f};
      mem_m   = (byte_in[7:4] == `SERE_DA_MEM) && (byte_in[3:2] == `SERE_DA_ZERO);
      spc_m   = (byte_in[7:4] == `SERE_DA_SPC) && (byte_in[3:2] == `SERE_DA_ZERO);

      // Byte that the current pointer selects
      unique case (q.area)
         sere_pkg::AR_MEM: b = mem[q.addr];
         sere_pkg::AR_SER: b = SERIAL_NUM[{~q.sidx, 3'h7} -: 8];   // Index 0 is the top byte
         sere_pkg::AR_SEC: b = sec[q.kidx];
         sere_pkg::AR_LCK: b = 8'(q.locked) << `SERE_LCK_POS;      // Widen before shift
      endcase

      if (stop) begin
         // Back to standby, line released
         n.st     = sere_pkg::D_IDLE;
         n.oe     = 1'h0;
         n.acking = 1'h0;
      end else if (start) begin
         // Any partial command is dropped here
         n.st     = sere_pkg::D_DEVA;
         n.bitn   = 4'h0;
         n.oe     = 1'h0;
         n.acking = 1'h0;
      end else begin
         unique case (q.st)
            sere_pkg::D_IDLE: begin
               n.oe = 1'h0;
            end
            sere_pkg::D_DEVA, sere_pkg::D_WADR, sere_pkg::D_WDAT: begin
               if (rise) begin
                  n.sh   = byte_in;
                  n.bitn = q.bitn + 4'h1;
                  if (q.bitn == 4'h7) begin
                     n.st   = sere_pkg::D_ACK;
                     n.bitn = 4'h0;
                     if (q.st == sere_pkg::D_DEVA) begin
                        // Unmatched address: no ack, standby
                        n.ackok = mem_m | spc_m;
                        n.nxt   = byte_in[`SERE_DA_RW] ? sere_pkg::D_RDAT : sere_pkg::D_WADR;
                        if (mem_m) begin
                           n.area = sere_pkg::AR_MEM;
                           if (!byte_in[`SERE_DA_RW]) begin
                              n.half = byte_in[`SERE_DA_HALF];
                           end
                        end else begin
                           n.area = q.smode;
                        end
                     end else if (q.st == sere_pkg::D_WADR) begin
                        // Word address of the dummy write
                        n.ackok = 1'h1;
                        n.nxt   = sere_pkg::D_WDAT;
                        if (q.area == sere_pkg::AR_MEM) begin
                           n.addr = {q.half, byte_in};
                        end else if (byte_in[`SERE_WA_LCK_BIT]) begin
                           n.smode = sere_pkg::AR_LCK;
                           n.area  = sere_pkg::AR_LCK;
                        end else if (byte_in[7:6] == `SERE_WA_SER) begin
                           n.smode = sere_pkg::AR_SER;
                           n.area  = sere_pkg::AR_SER;
                           n.sidx  = byte_in[3:0];
                        end else if (byte_in[7:6] == `SERE_WA_SEC) begin
                           n.smode = sere_pkg::AR_SEC;
                           n.area  = sere_pkg::AR_SEC;
                           n.kidx  = byte_in[3:0];
                        end else begin
                           n.ackok = 1'h0;
                        end
                     end else begin
                        // Data bytes are discarded; in the security and lock areas the ack tells the lock state
                        n.nxt   = sere_pkg::D_WDAT;
                        n.ackok = (q.area == sere_pkg::AR_MEM) |
                                  (((q.area == sere_pkg::AR_SEC) |
                                    (q.area == sere_pkg::AR_LCK)) & ~q.locked);
                     end
                  end
               end
            end
            sere_pkg::D_ACK: begin
               if (fall) begin
                  if (!q.acking) begin
                     n.acking = 1'h1;
                     n.oe     = q.ackok;
                  end else begin
                     n.acking = 1'h0;
                     n.oe     = 1'h0;
                     if (!q.ackok) begin
                        n.st = sere_pkg::D_IDLE;
                     end else if (q.nxt == sere_pkg::D_RDAT) begin
                        // First data bit goes out as the ack is released
                        n.st   = sere_pkg::D_RDAT;
                        n.oe   = ~b[7];
                        n.sh   = {b[6:0], 1'h0};
                        n.bitn = 4'h1;
                     end else begin
                        n.st = q.nxt;
                     end
                  end
               end
            end
            sere_pkg::D_RDAT: begin
               if (fall) begin
                  if (q.bitn == 4'h8) begin
                     n.oe = 1'h0;
                     n.st = sere_pkg::D_RACK;
                     // Pointer moves after every byte out, except in the lock area
                     unique case (q.area)
                        sere_pkg::AR_MEM: n.addr = q.addr + 9'h001;
                        sere_pkg::AR_SER: n.sidx = q.sidx + 4'h1;
                        sere_pkg::AR_SEC: n.kidx = q.kidx + 4'h1;
                        sere_pkg::AR_LCK: n.sh   = q.sh;            // Same byte again
                     endcase
                  end else begin
                     n.oe   = ~q.sh[7];
                     n.sh   = {q.sh[6:0], 1'h0};
                     n.bitn = q.bitn + 4'h1;
                  end
               end
            end
            sere_pkg::D_RACK: begin
               if (rise) begin
                  // Ack continues the stream, nack returns to standby
                  n.st = q.sda_f ? sere_pkg::D_IDLE : sere_pkg::D_RNXT;
               end
            end
            sere_pkg::D_RNXT: begin
               if (fall) begin
                  n.st   = sere_pkg::D_RDAT;  // Next byte
                  n.oe   = ~b[7];
                  n.sh   = {b[6:0], 1'h0};
                  n.bitn = 4'h1;
               end
            end
            default: begin
               n.st = sere_pkg::D_IDLE;
               n.oe = 1'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; idle bus levels at reset avoid a false start
   always_ff @(posedge link.link_clk or negedge NRST) begin
      if (!NRST) begin
         q       <= '0;
         q.scl_m <= 3'h7;
         q.sda_m <= 3'h7;
         q.scl_f <= 1'h1;
         q.scl_p <= 1'h1;
         q.sda_f <= 1'h1;
         q.sda_p <= 1'h1;
         q.st    <= sere_pkg::D_IDLE;
         q.nxt   <= sere_pkg::D_IDLE;
         q.area  <= sere_pkg::AR_MEM;
         q.smode <= sere_pkg::AR_SEC;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; open drain so the data level is always low
   assign link.sda_d_o  = 1'h0;
   assign link.sda_d_oe = q.oe;
   assign BUSY          = (q.st != sere_pkg::D_IDLE);
   assign ADDR_CNT      = q.addr;

endmodule // sere_dev

// *** hdl/sere_ctl.sv ***
`timescale 1ns/1ps
`include "sere_cfg.svh"
module sere_ctl (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        NRST,
   // Bus link; this end makes the link clock
   sere_link_if.ctl         link,
   // Command
   input  wire logic        CMD_VALID,
   output logic             CMD_READY,
   input  wire logic [2:0]  CMD_OP,
   input  wire logic [8:0]  CMD_ADDR,
   input  wire logic [7:0]  CMD_LEN,
   // Results
   output logic             RD_VALID,
   output logic [7:0]       RD_DATA,
   output logic             DONE,
   output logic             NACK,
   output logic             PROBE_LOCKED
);

   sere_pkg::sere_ctl_t q;
   sere_pkg::sere_ctl_t n;
   logic                tick;

   // Device address byte for a command
   function automatic logic [7:0] dev_addr(sere_pkg::sere_op_t op, logic half, logic rd);
      if (op == sere_pkg::OP_CUR || op == sere_pkg::OP_RND) begin
         dev_addr = {`SERE_DA_MEM, `SERE_DA_ZERO, half, rd};
      end else begin
         dev_addr = {`SERE_DA_SPC, `SERE_DA_ZERO, 1'h0, rd};
      end
   endfunction

   // Word address byte; area index comes from the low address bits
   function automatic logic [7:0] word_addr(sere_pkg::sere_op_t op, logic [8:0] a);
      unique case (op)
         sere_pkg::OP_SER: word_addr = {`SERE_WA_SER, 2'h0, a[3:0]}; // Zero gives byte one
         sere_pkg::OP_SEC,
         sere_pkg::OP_PRB: word_addr = {`SERE_WA_SEC, 2'h0, a[3:0]};
         sere_pkg::OP_LCK: word_addr = `SERE_WA_LOCK | a[7:0]; // Lock bit forced, rest free
         default:          word_addr = a[7:0];
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bit engine: four quarters per bit, data changes while SCL is low except for start and stop
   always_comb begin
      n          = q;
      n.lclk     = ~q.lclk;            // Link clock is half the system clock
      n.rd_valid = 1'h0;
      n.done     = 1'h0;
      n.sda_m    = {q.sda_m[1:0], link.sda};
      if (q.sda_m[1] == q.sda_m[2]) begin
         n.sda_f = q.sda_m[2];
      end
      tick  = (q.cnt == 8'(`SERE_QTR_CYC - 1));
      n.cnt = tick ? 8'h00 : q.cnt + 8'h01;
      if (q.st == sere_pkg::H_IDLE) begin
         n.cnt = 8'h00;
         n.qp  = 2'h0;
         if (CMD_VALID) begin
            n.op   = sere_pkg::sere_op_t'(CMD_OP);
            n.addr = CMD_ADDR;
            n.len  = (CMD_LEN == 8'h00) ? 8'h01 : CMD_LEN;
            n.nack = 1'h0;
            n.ph   = (CMD_OP == sere_pkg::OP_CUR) ? sere_pkg::PH_DAR : sere_pkg::PH_DAW;
            n.st   = sere_pkg::H_STA;
         end
      end else if (tick) begin
         n.qp = q.qp + 2'h1;
         unique case (q.st)
            sere_pkg::H_STA: begin
               unique case (q.qp)
                  2'h0: n.oe  = 1'h0;
                  2'h1: n.scl = 1'h1;
                  2'h2: n.oe  = 1'h1;
                  2'h3: begin
                     n.scl = 1'h0;
                     if (q.ph == sere_pkg::PH_PSTA) begin
                        n.st = sere_pkg::H_STO;   // Start then stop after probe
                     end else begin
                        n.st   = sere_pkg::H_TX;
                        n.sh   = dev_addr(q.op, q.addr[8], q.ph == sere_pkg::PH_DAR);
                        n.bitn = 4'h0;
                     end
                  end
               endcase
            end
            sere_pkg::H_TX: begin
               unique case (q.qp)
                  2'h0: n.oe  = (q.bitn != 4'h8) & ~q.sh[7];
                  2'h1: n.scl = 1'h1;
                  2'h2: n.ackn = (q.bitn == 4'h8) ? q.sda_f : q.ackn;
                  2'h3: begin
                     n.scl = 1'h0;
                     if (q.bitn != 4'h8) begin
                        n.sh   = {q.sh[6:0], 1'h0};
                        n.bitn = q.bitn + 4'h1;
                     end else if (q.ackn && q.ph != sere_pkg::PH_PD) begin
                        n.nack = 1'h1;
                        n.st   = sere_pkg::H_STO;
                     end else begin
                        n.bitn = 4'h0;
                        unique case (q.ph)
                           sere_pkg::PH_DAW: begin
                              n.ph = sere_pkg::PH_WA;
                              n.sh = word_addr(q.op, q.addr);
                           end
                           sere_pkg::PH_WA: begin
                              if (q.op == sere_pkg::OP_PRB) begin
                                 n.ph = sere_pkg::PH_PD;
                                 n.sh = 8'h00;
                              end else begin
                                 n.ph = sere_pkg::PH_DAR;   // Restart to read
                                 n.st = sere_pkg::H_STA;
                              end
                           end
                           sere_pkg::PH_PD: begin
                              n.locked = q.ackn;
                              n.ph     = sere_pkg::PH_PSTA;
                              n.st     = sere_pkg::H_STA;
                           end
                           sere_pkg::PH_DAR: begin
                              n.ph = sere_pkg::PH_RD;
                              n.st = sere_pkg::H_RX;
                           end
                           default: n.st = sere_pkg::H_STO;
                        endcase
                     end
                  end
               endcase
            end
            sere_pkg::H_RX: begin
               unique case (q.qp)
                  2'h0: n.oe  = (q.bitn == 4'h8) & (q.len > 8'h01);  // Nack the last
                  2'h1: n.scl = 1'h1;
                  2'h2: begin
                     if (q.bitn != 4'h8) begin
                        n.sh = {q.sh[6:0], q.sda_f};
                     end
                     if (q.bitn == 4'h7) begin
                        n.rd_valid = 1'h1;
                        n.rd_data  = {q.sh[6:0], q.sda_f};
                     end
                  end
                  2'h3: begin
                     n.scl = 1'h0;
                     if (q.bitn != 4'h8) begin
                        n.bitn = q.bitn + 4'h1;
                     end else if (q.len > 8'h01) begin
                        n.len  = q.len - 8'h01;      // Ack asks for more
                        n.bitn = 4'h0;
                     end else begin
                        n.st = sere_pkg::H_STO;
                     end
                  end
               endcase
            end
            sere_pkg::H_STO: begin
               unique case (q.qp)
                  2'h0: n.oe  = 1'h1;
                  2'h1: n.scl = 1'h1;
                  2'h2: n.oe  = 1'h0;
                  2'h3: begin
                     n.st   = sere_pkg::H_IDLE;
                     n.done = 1'h1;
                  end
               endcase
            end
            default: n.st = sere_pkg::H_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         q       <= '0;
         q.st    <= sere_pkg::H_IDLE;
         q.ph    <= sere_pkg::PH_DAW;
         q.op    <= sere_pkg::OP_CUR;
         q.scl   <= 1'h1;
         q.sda_m <= 3'h7;
         q.sda_f <= 1'h1;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign link.link_clk = q.lclk;
   assign link.scl      = q.scl;
   assign link.sda_h_o  = 1'h0;
   assign link.sda_h_oe = q.oe;
   assign CMD_READY     = (q.st == sere_pkg::H_IDLE);
   assign RD_VALID      = q.rd_valid;
   assign RD_DATA       = q.rd_data;
   assign DONE          = q.done;
   assign NACK          = q.nack;
   assign PROBE_LOCKED  = q.locked;

endmodule // sere_ctl

// *** test/sere_link_checker.sv ***
`timescale 1ns/1ps
module sere_link_checker (
   // Link wires
   input wire logic link_clk,
   input wire logic NRST,
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_h_o,
   input wire logic sda_h_oe,
   input wire logic sda_d_o,
   input wire logic sda_d_oe
);
   logic [1:0] warm_q;
   // No sampled history before the first link edges, so hold checks off briefly
   always_ff @(posedge link_clk or negedge NRST) begin
      if (!NRST) begin
         warm_q <= 2'h0;
      end else if (warm_q != 2'h3) begin
         warm_q <= warm_q + 2'h1;
      end
   end
   default clocking @(posedge link_clk); endclocking
   default disable iff (!NRST || (warm_q != 2'h3));
   ////////////////////////////////////////
   // Open drain ends, device data moves only while the clock is low
   od_low_only_a: assert property (
      !(sda_h_oe && sda_h_o) && !(sda_d_oe && sda_d_o)) else $error("driver pulls high");
   one_high_driver_a: assert property (
      scl && sda_d_oe |-> !sda_h_oe) else $error("both ends drive on high clock");
   dev_low_move_a: assert property (
      $changed(sda_d_oe) |-> !scl) else $error("device moved data on high clock");
   ctl_edge_move_a: assert property (
      scl && $past(scl) && $changed(sda_h_oe) |-> !sda_d_oe) else $error("edge under device");
   // Start and stop belong to the controller alone
   start_by_ctl_a: assert property (
      scl && $past(scl) && $fell(sda) |-> sda_h_oe && !sda_d_oe) else $error("bad start");
   start_high_a: assert property (
      scl && $rose(sda_h_oe) |-> $past(sda)) else $error("start from low line");
   stop_release_a: assert property (
      scl && $past(scl) && $rose(sda) |-> !sda_d_oe) else $error("device held stop");
   // Bit clock phases have a floor; the low phase also has a ceiling
   scl_high_len_a: assert property (
      $rose(scl) |=> scl[*8]) else $error("clock high too short");
   scl_low_len_a: assert property (
      $fell(scl) |=> !scl[*8] ##[1:40] scl) else $error("clock low out of range");
endmodule // sere_link_checker

// *** test/test_serial_eeprom_read_engine.sv ***
`timescale 1ns/1ps
module test_serial_eeprom_read_engine;
   // Arbitrary serial value
   localparam logic [127:0] SN = 128'h1122_3344_5566_7788_99AA_BBCC_DDEE_FF01;
   logic       clk = 0, nrst = 1, cv = 0, locked = 1, we = 0, lsec = 0;
   logic [2:0] op = 3'h0;
   logic [8:0] ca = 9'h000, la = 9'h000, acnt;
   logic [7:0] cl = 8'h01, ld = 8'h00, rd;
   logic       cr, rv, done, nk, plk, busy;
   logic [7:0] rq[$];
   int         n_mismatch = 0, cmp_count = 0;
   always #20 clk = ~clk;
   ////////////////////////////////////////
   sere_link_if link ();
   sere_ctl u_sere_ctl (.CLK_SYS(clk), .NRST(nrst), .link(link), .CMD_VALID(cv),
      .CMD_READY(cr), .CMD_OP(op), .CMD_ADDR(ca), .CMD_LEN(cl), .RD_VALID(rv),
      .RD_DATA(rd), .DONE(done), .NACK(nk), .PROBE_LOCKED(plk));
   sere_dev #(.SERIAL_NUM(SN)) u_sere_dev (.NRST(nrst), .link(link), .LOCKED(locked),
      .LD_WE(we), .LD_SEC(lsec), .LD_ADDR(la), .LD_DATA(ld), .BUSY(busy), .ADDR_CNT(acnt));
   sere_link_checker u_sere_link_checker (.link_clk(link.link_clk), .NRST(nrst),
      .scl(link.scl), .sda(link.sda), .sda_h_o(link.sda_h_o), .sda_h_oe(link.sda_h_oe),
      .sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe));
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Half bit folded in so a lost page bit shows
   function automatic logic [7:0] mv(input logic [8:0] a);
      return {a[8], a[6:0]} ^ 8'h5A;
   endfunction
   task automatic load(input logic s, input logic [8:0] a, input logic [7:0] d);
      @(posedge link.link_clk);
      {we, lsec, la, ld} <= {1'b1, s, a, d};
      @(posedge link.link_clk);
      we <= 1'b0;
   endtask
   // One command, bytes gathered until the end pulse
   task automatic cmd(input logic [2:0] o, input logic [8:0] a, input logic [7:0] n);
      int i;
      rq.delete();
      @(posedge clk);
      {cv, op, ca, cl} <= {1'b1, o, a, n};
      @(posedge clk);
      cv <= 1'b0;
      for (i = 0; i < 20000; i++) begin
         @(posedge clk);
         if (i == 0) chk("ready", 9'h000, {8'h00, cr});
         if (rv === 1'b1) rq.push_back(rd);
         if (done === 1'b1) break;
      end
      chk("done", 9'h001, {8'h00, done});
      chk("ready", 9'h001, {8'h00, cr});
      chk("busy", 9'h000, {8'h00, busy});
   endtask
   ////////////////////////////////////////
   task automatic s_mem;
      int k;
      for (k = 0; k < 4; k++) load(1'b0, 9'h1FE + 9'(k), mv(9'h1FE + 9'(k)));
      cmd(sere_pkg::OP_RND, 9'h1FE, 8'h03);
      for (k = 0; k < 3; k++) chk("mem", {1'b0, mv(9'h1FE + 9'(k))}, {1'b0, rq[k]});
      chk("count", 9'h003, 9'(rq.size()));
      chk("addr", 9'h001, acnt);
      chk("nack", 9'h000, {8'h00, nk});
      cmd(sere_pkg::OP_CUR, 9'h000, 8'h01);
      chk("cur", {1'b0, mv(9'h001)}, {1'b0, rq[0]});
   endtask
   task automatic s_ser;
      int k;
      int j;
      cmd(sere_pkg::OP_SER, 9'h00E, 8'h03);
      for (k = 0; k < 3; k++) begin
         j = (14 + k) % 16; // Index wraps past the sixteenth byte
         chk("ser", {1'b0, SN[127 - 8 * j -: 8]}, {1'b0, rq[k]});
      end
      cmd(sere_pkg::OP_SER, 9'h000, 8'h01);
      chk("ser0", {1'b0, SN[127 -: 8]}, {1'b0, rq[0]});
   endtask
   task automatic s_sec;
      load(1'b1, 9'h00F, 8'hC5);
      load(1'b1, 9'h000, 8'h3A);
      cmd(sere_pkg::OP_SEC, 9'h00F, 8'h02);
      chk("sec", 9'h0C5, {1'b0, rq[0]});
      chk("wrap", 9'h03A, {1'b0, rq[1]});
   endtask
   // Lock read and probe, locked then unlocked
   task automatic s_lck;
      cmd(sere_pkg::OP_LCK, 9'h040, 8'h02);
      chk("lock", 9'h001, {8'h00, rq[0][1]});
      chk("again", {1'b0, rq[0]}, {1'b0, rq[1]});
      cmd(sere_pkg::OP_PRB, 9'h000, 8'h01);
      chk("probe", 9'h001, {8'h00, plk});
      locked <= 1'b0;
      cmd(sere_pkg::OP_PRB, 9'h000, 8'h01);
      chk("probe", 9'h000, {8'h00, plk});
      cmd(sere_pkg::OP_LCK, 9'h0C0, 8'h01);
      chk("unlock", 9'h000, {8'h00, rq[0][1]});
   endtask
   ////////////////////////////////////////
   task final_report;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      @(posedge clk);
      nrst <= 1'b0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (16) @(posedge clk);
      s_mem;
      s_ser;
      s_sec;
      s_lck;
      final_report;
   end
   // Watchdog, well past the expected run
   initial begin
      #4_000_000;
      n_mismatch++;
      final_report;
   end
endmodule // test_serial_eeprom_read_engine
